// ===== design/gp_timer_compare_enable.sv
/*
  Timer enable, timeout compare and interrupt enable block with its
  APB register slave, counter and slow-domain enable hand-over.
  Assumes an APB3 master on pclk; single clock, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module gp_timer_compare_enable (
  input wire logic pclk, // Bus and block clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  output logic [31:0] count_value, // Current count
  output logic run_active, // Applied run enable
  output logic match_a_irq, // Field A match flag
  output logic match_b_irq, // Field B match flag
  output logic match_c_irq, // Field C match flag
  output logic roll_irq // Rollover flag
);
  // Bus slave state
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_data;
  logic addr_ok;
  logic wr_en;

  // Software visible state
  logic [gpt_pkg::CFG_WIDTH-1:0] timer_config_q;
  logic [3:0] irq_enable_mask_q;
  logic [3:0] flag_q;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [15:0] match_low_q [0:2];
  logic [15:0] match_high_q [0:2];
  logic [31:0] match_field [0:2];

  // Engine links
  logic run_req;
  logic run_applied;
  logic sync_busy;
  logic [31:0] count_q;
  logic step_q;
  logic roll_q;
  logic free_run;
  logic count_direction;

  assign free_run = timer_config_q[gpt_pkg::CFG_FREE_RUN];
  assign count_direction = timer_config_q[gpt_pkg::CFG_DOWN];

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign count_value = count_q;
  assign run_active = run_applied;
  assign match_a_irq = flag_q[0];
  assign match_b_irq = flag_q[1];
  assign match_c_irq = flag_q[2];
  assign roll_irq = flag_q[gpt_pkg::BIT_ROLL];

  // A write lands only at the edge that completes the access
  assign wr_en = psel && penable && pready_q && pwrite && addr_ok;

  // Read mux and address decode; reserved bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      gpt_pkg::ADDR_COUNT_LOW: begin
        rd_data = {16'h0000, count_q[15:0]};
      end
      gpt_pkg::ADDR_COUNT_HIGH: begin
        rd_data = {16'h0000, count_q[31:16]};
      end
      gpt_pkg::ADDR_CONFIG: begin
        rd_data = {25'h000_0000, timer_config_q};
      end
      gpt_pkg::ADDR_RUN: begin
        rd_data = {31'h0000_0000, run_req};
      end
      gpt_pkg::ADDR_IEN: begin
        rd_data = {28'h000_0000, irq_enable_mask_q};
      end
      gpt_pkg::ADDR_STATE: begin
        rd_data = {23'h00_0000, sync_busy, 4'h0, flag_q};
      end
      gpt_pkg::ADDR_CLEAR: begin
        rd_data = 32'h0000_0000; // Clear register is write-only
      end
      default: begin
        addr_ok = 1'b0;
        for (int i = 0; i < 3; i++) begin
          if (paddr == gpt_pkg::MATCH_LOW_ADDR[i]) begin
            rd_data = {16'h0000, match_low_q[i]};
            addr_ok = 1'b1;
          end
          if (paddr == gpt_pkg::MATCH_HIGH_ADDR[i]) begin
            rd_data = {16'h0000, match_high_q[i]};
            addr_ok = 1'b1;
          end
        end
      end
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addr_ok;
    end
  end

  // Read data captured with ready, so it is stable at sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && penable && !pready_q) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  // Counter config; stored bits only, reserved writes dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_config_q <= gpt_pkg::CONFIG_RESET[gpt_pkg::CFG_WIDTH-1:0];
    end else if (wr_en && paddr == gpt_pkg::ADDR_CONFIG) begin
      timer_config_q <= pwdata[gpt_pkg::CFG_WIDTH-1:0];
    end
  end

  // Interrupt enables double as compare enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_mask_q <= gpt_pkg::IEN_RESET[3:0];
    end else if (wr_en && paddr == gpt_pkg::ADDR_IEN) begin
      irq_enable_mask_q <= pwdata[3:0];
    end
  end

  // Match field halves, one pair per field
  for (genvar g = 0; g < 3; g++) begin : g_field
    // No gating on run state: A and B and free-run C take writes anytime
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        match_low_q[g] <= gpt_pkg::MATCH_LOW_RESET[g];
      end else if (wr_en && paddr == gpt_pkg::MATCH_LOW_ADDR[g]) begin
        match_low_q[g] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        match_high_q[g] <= gpt_pkg::MATCH_HIGH_RESET;
      end else if (wr_en && paddr == gpt_pkg::MATCH_HIGH_ADDR[g]) begin
        match_high_q[g] <= pwdata[15:0];
      end
    end

    // High half forms bits 31..16
    assign match_field[g] = {match_high_q[g], match_low_q[g]};

    // Compare only when enabled, on the fresh count
    assign flag_set[g] = step_q && irq_enable_mask_q[g] && (count_q == match_field[g]);
  end

  // Rollover only counts in free-running mode
  assign flag_set[gpt_pkg::BIT_ROLL] = roll_q && free_run && irq_enable_mask_q[gpt_pkg::BIT_ROLL];

  // Clear strobes from the write-only clear register
  assign flag_clr = (wr_en && paddr == gpt_pkg::ADDR_CLEAR) ? pwdata[3:0] : 4'h0;

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  // Run enable passes through the slow-domain hand-over
  run_enable_sync u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .wr(wr_en && paddr == gpt_pkg::ADDR_RUN),
    .wdata(pwdata[gpt_pkg::BIT_RUN]),
    .run_req(run_req),
    .run_applied(run_applied),
    .busy(sync_busy)
  );

  // Counter runs only on the applied enable
  count_engine u_count (
    .clk(pclk),
    .rst_n(presetn),
    .run(run_applied),
    .free_run(free_run),
    .count_direction(count_direction),
    .prescale(timer_config_q[gpt_pkg::CFG_PRE_LSB +: 2]),
    .limit(match_field[2]),
    .count_q(count_q),
    .step_q(step_q),
    .roll_q(roll_q)
  );

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completing write access to a given address
  sequence s_apb_wr(logic [31:0] addr);
    psel && penable && pready_q && pwrite && paddr == addr;
  endsequence

  // Setup followed by first access cycle
  sequence s_apb_start;
    psel && !penable ##1 psel && penable && !pready_q;
  endsequence

  // Fresh count equal to one field
  sequence s_hit(int idx);
    step_q && count_q == match_field[idx];
  endsequence

  // Equal count while that compare is enabled
  sequence s_hit_on(int idx);
    s_hit(idx) ##0 irq_enable_mask_q[idx];
  endsequence

  // Clear write for one flag with no new event
  sequence s_clr(int idx);
    s_apb_wr(gpt_pkg::ADDR_CLEAR) ##0 pwdata[idx] && !flag_set[idx];
  endsequence

  // Ready one cycle after access start
  a_ready_timing: assert property (s_apb_start |=> pready_q)
    else $error("ready not one cycle after access start");

  // Ready stands for one cycle only
  a_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("ready held too long");

  // No ready without a selected access
  a_idle_no_ready: assert property (!psel |=> !pready_q)
    else $error("ready without select");

  // Unmapped address answers with an error
  a_unmapped_err: assert property (psel && penable && !pready_q && !addr_ok |=> pready_q && pslverr_q)
    else $error("unmapped access without error");

  // Writes hand back zero read data
  a_write_zero_data: assert property (pready_q && pwrite |-> prdata_q == 32'h0000_0000)
    else $error("write returned data");

  // Field A high half lands while running too
  a_field_a_write: assert property (s_apb_wr(gpt_pkg::MATCH_HIGH_ADDR[0])
    |=> match_high_q[0] == $past(pwdata[15:0])) else $error("field A high write lost");

  // Low half fills bits 15..0
  a_field_a_low: assert property (s_apb_wr(gpt_pkg::MATCH_LOW_ADDR[0])
    |=> match_field[0][15:0] == $past(pwdata[15:0])) else $error("field A low write lost");

  // High half fills bits 31..16
  a_field_b_high: assert property (s_apb_wr(gpt_pkg::MATCH_HIGH_ADDR[1])
    |=> match_field[1][31:16] == $past(pwdata[15:0])) else $error("field B high write lost");

  // Field C takes writes while free running
  a_field_c_free: assert property ((free_run && run_applied) ##0 s_apb_wr(gpt_pkg::MATCH_LOW_ADDR[2])
    |=> match_low_q[2] == $past(pwdata[15:0])) else $error("free-run C write lost");

  // Disabled field A never raises its flag
  a_flag_gated: assert property ($rose(flag_q[0]) |-> $past(irq_enable_mask_q[0]))
    else $error("flag A set while disabled");

  // Same for field B
  a_flag_b_gated: assert property ($rose(flag_q[1]) |-> $past(irq_enable_mask_q[1]))
    else $error("flag B set while disabled");

  // Same for field C
  a_flag_c_gated: assert property ($rose(flag_q[2]) |-> $past(irq_enable_mask_q[2]))
    else $error("flag C set while disabled");

  // No compare for B while its enable is clear
  a_no_compare_off: assert property (!irq_enable_mask_q[1] && !flag_q[1] |=> !flag_q[1])
    else $error("compare B ran while disabled");

  // No compare for A while its enable is clear
  a_no_compare_a: assert property (!irq_enable_mask_q[0] && !flag_q[0] |=> !flag_q[0])
    else $error("compare A ran while disabled");

  // No compare for C while its enable is clear
  a_no_compare_c: assert property (!irq_enable_mask_q[2] && !flag_q[2] |=> !flag_q[2])
    else $error("compare C ran while disabled");

  // Enabled match on C is flagged
  a_match_sets: assert property (s_hit_on(2) |=> flag_q[2])
    else $error("field C match not flagged");

  // Enabled match on A is flagged
  a_match_a_sets: assert property (s_hit_on(0) |=> flag_q[0])
    else $error("field A match not flagged");

  // Enabled match on B is flagged
  a_match_b_sets: assert property (s_hit_on(1) |=> flag_q[1])
    else $error("field B match not flagged");

  // Flag C only follows an exact full-width hit
  a_flag_on_step: assert property ($rose(flag_q[2])
    |-> $past(step_q) && $past(count_q) == $past(match_field[2])) else $error("flag C without match");

  // Enabled rollover is flagged
  a_roll_sets: assert property (roll_q && free_run && irq_enable_mask_q[3] |=> flag_q[3])
    else $error("rollover not flagged");

  // Rollover flag only in free-running mode
  a_roll_free_only: assert property ($rose(flag_q[3]) |-> $past(free_run))
    else $error("rollover flagged in periodic mode");

  // Clear write drops flag B
  a_clear_works: assert property (s_clr(1) |=> !flag_q[1])
    else $error("flag B not cleared");

  // Clear write drops flag A
  a_clear_a: assert property (s_clr(0) |=> !flag_q[0])
    else $error("flag A not cleared");

  // A new event wins over a clear
  a_set_beats_clr: assert property (flag_set[0] |=> flag_q[0])
    else $error("set lost against clear");

  // Flags stay up until cleared
  a_flag_sticky: assert property (flag_q[2] && !flag_clr[2] |=> flag_q[2])
    else $error("flag C dropped without clear");

  // Run enable write raises sync busy
  a_run_write_busy: assert property (s_apb_wr(gpt_pkg::ADDR_RUN) |=> sync_busy)
    else $error("sync busy not raised");

  // A stopped timer never steps
  a_stopped_no_step: assert property (!run_applied |=> !step_q)
    else $error("count stepped while stopped");
endmodule
`default_nettype wire

// ===== design/gpt_pkg.sv
/*
  Constants shared by the timer compare/enable block: register byte
  addresses, field positions, reset values and timing counts.
  Assumes a 125 MHz pclk and an APB register bus with 32-bit data.

*/
package gpt_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_COUNT_LOW = 32'h4000_0000;
  localparam logic [31:0] ADDR_COUNT_HIGH = 32'h4000_0004;
  localparam logic [31:0] ADDR_CONFIG = 32'h4000_0008;
  localparam logic [31:0] ADDR_RUN = 32'h4000_000c;
  localparam logic [31:0] ADDR_IEN = 32'h4000_0028;
  localparam logic [31:0] ADDR_STATE = 32'h4000_002c;
  localparam logic [31:0] ADDR_CLEAR = 32'h4000_0030;
  // Match fields in order A, B, C
  localparam logic [31:0] MATCH_LOW_ADDR [0:2] = '{32'h4000_0010, 32'h4000_0018, 32'h4000_0020};
  localparam logic [31:0] MATCH_HIGH_ADDR [0:2] = '{32'h4000_0014, 32'h4000_001c, 32'h4000_0024};
  localparam logic [15:0] MATCH_LOW_RESET [0:2] = '{16'h1fff, 16'h2fff, 16'h3fff};
  localparam logic [15:0] MATCH_HIGH_RESET = 16'h0000;
  localparam logic [15:0] RUN_RESET = 16'h0000;
  localparam logic [15:0] IEN_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0040;
  // Field positions
  localparam int BIT_RUN = 0;
  localparam int BIT_ROLL = 3;
  localparam int BIT_SYNC_BUSY = 8;
  localparam int CFG_PRE_LSB = 0;
  localparam int CFG_DOWN = 2;
  localparam int CFG_FREE_RUN = 4;
  localparam int CFG_WIDTH = 7;
  // Prescaler divisors, pclk based
  localparam logic [15:0] PRE_DIV [0:3] = '{16'h0004, 16'h0010, 16'h0100, 16'h8000};
  // Slow domain rate and its tick period in pclk cycles
  localparam longint CLK_FREQ_HZ = 125_000_000;
  localparam longint SLOW_FREQ_HZ = 32_768;
  localparam logic [11:0] SLOW_TICK_CYCLES = 12'(CLK_FREQ_HZ / SLOW_FREQ_HZ);
endpackage

// ===== design/run_enable_sync.sv
/*
  Run-enable hand-over to the 32.768 kHz domain, modelled as a tick
  enable from a pclk divider. Assumes single pclk, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module run_enable_sync (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire logic wr, // Run enable write pulse
  input wire logic wdata, // Written run enable
  output logic run_req, // Software view of run enable
  output logic run_applied, // Enable as seen by the slow side
  output logic busy // Change still in flight
);
  logic [11:0] div_q;
  logic tick;

  // Slow-domain tick divider
  assign tick = (div_q == gpt_pkg::SLOW_TICK_CYCLES - 12'h001);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 12'h000;
    end else if (tick) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  // Requested value follows software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_req <= 1'b0;
    end else if (wr) begin
      run_req <= wdata;
    end
  end

  // Applied value changes only on a slow tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_applied <= 1'b0;
    end else if (tick) begin
      run_applied <= run_req;
    end
  end

  // A write in the tick cycle keeps busy set: set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (wr) begin
      busy <= 1'b1;
    end else if (tick) begin
      busy <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_busy_on_write: assert property (wr |=> busy) else $error("busy not set by write");
  a_busy_drops_tick: assert property ($fell(busy) |-> $past(tick) && run_applied == $past(run_req))
    else $error("busy cleared without apply");
endmodule
`default_nettype wire

// ===== design/count_engine.sv
/*
  32-bit up/down counter with prescaler and periodic/free-run wrap.
  Assumes mode inputs are stable while running.
*/
`timescale 1ns/1ps
`default_nettype none
module count_engine (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire logic run, // Applied run enable
  input wire logic free_run, // 1: wrap full range
  input wire logic count_direction, // 1: count down
  input wire logic [1:0] prescale, // Divisor select
  input wire logic [31:0] limit, // Field C
  output logic [31:0] count_q, // Current count
  output logic step_q, // Count updated last edge
  output logic roll_q // Free-run wrap last edge
);
  logic [15:0] pre_q;
  logic [15:0] pre_max;
  logic tick;
  logic [31:0] start;

  assign pre_max = gpt_pkg::PRE_DIV[prescale] - 16'h0001;
  assign tick = run && (pre_q == pre_max);
  assign start = count_direction ? 32'hffff_ffff : 32'h0000_0000;

  // Prescaler, cleared while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 16'h0000;
    end else if (!run || tick) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // Counter: held at start while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 32'h0000_0000;
    end else if (!run) begin
      count_q <= start;
    end else if (tick) begin
      if (!free_run && count_q == limit) begin
        count_q <= start;
      end else if (count_direction) begin
        count_q <= count_q - 32'h0000_0001;
      end else begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // Step and rollover pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'b0;
      roll_q <= 1'b0;
    end else begin
      step_q <= tick;
      roll_q <= tick && free_run && (count_q == ~start);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hold_start: assert property (!run |=> count_q == $past(start)) else $error("stopped count not at start");
  a_period_wrap: assert property (tick && !free_run && count_q == limit |=> count_q == $past(start))
    else $error("periodic restart missed");
endmodule
`default_nettype wire

// ===== test/gp_timer_compare_enable_test.sv
/*
  Self-checking bench for the timer compare/enable block: APB read and
  write tasks, register reset values, periodic and free-running compare.
  Assumes the design's package and modules are compiled beforehand.
*/
`timescale 1ns/1ps
`default_nettype none
module gp_timer_compare_enable_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] count_value;
  logic run_active;
  logic match_a_irq;
  logic match_b_irq;
  logic match_c_irq;
  logic roll_irq;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] max_count = 32'h0000_0000;
  logic max_clr = 1'b0;
  logic [31:0] rd_data;
  logic rd_err;
  logic [31:0] lo_rst [0:2] = '{32'h0000_1fff, 32'h0000_2fff, 32'h0000_3fff};

  // 125 MHz clock
  always #4 pclk = ~pclk;

  gp_timer_compare_enable u_gp_timer_compare_enable (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .count_value(count_value),
    .run_active(run_active),
    .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq),
    .match_c_irq(match_c_irq),
    .roll_irq(roll_irq)
  );

  // Highest count while running; shows where the counter wrapped
  always @(posedge pclk) begin
    if (max_clr) begin
      max_count <= 32'h0000_0000;
    end else if (run_active === 1'b1 && count_value > max_count) begin
      max_count <= count_value;
    end
  end

  task automatic conclude();
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      $display("unexpected at %0t: no ready", $time);
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
    apb_xfer(1'b1, addr, data);
    check_bit(rd_err, 1'b0, "write error");
  endtask

  task automatic reg_read_check(input logic [31:0] addr, input logic [31:0] exp);
    apb_xfer(1'b0, addr, 32'h0000_0000);
    check_bit(rd_err, 1'b0, "read error");
    check_word(rd_data, exp, "read data");
  endtask

  // Enable hand-over takes one slow tick, about 3814 cycles
  task automatic wait_run(input logic want);
    int n;
    n = 0;
    while (run_active !== want && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    check_bit(run_active, want, "applied run enable");
  endtask

  task automatic restart_max();
    max_clr <= 1'b1;
    @(posedge pclk);
    max_clr <= 1'b0;
  endtask

  task automatic check_flags(input logic a, input logic b, input logic c);
    @(negedge pclk);
    check_bit(match_a_irq, a, "flag a");
    check_bit(match_b_irq, b, "flag b");
    check_bit(match_c_irq, c, "flag c");
  endtask

  // Watchdog, generous against about 19k expected cycles
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    for (int i = 0; i < 3; i++) begin
      reg_read_check(gpt_pkg::MATCH_LOW_ADDR[i], lo_rst[i]);
      reg_read_check(gpt_pkg::MATCH_HIGH_ADDR[i], 32'h0000_0000);
    end
    reg_read_check(gpt_pkg::ADDR_RUN, 32'h0000_0000);
    reg_read_check(gpt_pkg::ADDR_IEN, 32'h0000_0000);
    reg_read_check(gpt_pkg::ADDR_STATE, 32'h0000_0000);
    reg_read_check(gpt_pkg::ADDR_CONFIG, 32'h0000_0040);
    check_bit(run_active, 1'b0, "idle run");
    check_word(count_value, 32'h0000_0000, "idle count");
    // Unmapped address answers with an error and zero data
    apb_xfer(1'b0, 32'h4000_0034, 32'h0000_0000);
    check_bit(rd_err, 1'b1, "unmapped error");
    check_word(rd_data, 32'h0000_0000, "unmapped data");
    // Halves keep 16 bits; reserved enable bits are dropped
    reg_write(gpt_pkg::MATCH_HIGH_ADDR[1], 32'habcd_1234);
    reg_read_check(gpt_pkg::MATCH_HIGH_ADDR[1], 32'h0000_1234);
    reg_write(gpt_pkg::MATCH_HIGH_ADDR[1], 32'h0000_0000);
    reg_write(gpt_pkg::ADDR_IEN, 32'h0000_fff0);
    reg_read_check(gpt_pkg::ADDR_IEN, 32'h0000_0000);
    // Periodic up, /4; A has a high half so it cannot match yet
    reg_write(gpt_pkg::ADDR_CONFIG, 32'h0000_0000);
    reg_write(gpt_pkg::MATCH_LOW_ADDR[2], 32'h0000_0010);
    reg_write(gpt_pkg::MATCH_HIGH_ADDR[2], 32'h0000_0000);
    reg_write(gpt_pkg::MATCH_LOW_ADDR[0], 32'h0000_0005);
    reg_write(gpt_pkg::MATCH_HIGH_ADDR[0], 32'h0000_0001);
    reg_write(gpt_pkg::MATCH_LOW_ADDR[1], 32'h0000_0008);
    reg_write(gpt_pkg::ADDR_IEN, 32'h0000_0005);
    reg_write(gpt_pkg::ADDR_RUN, 32'h0000_0001);
    reg_read_check(gpt_pkg::ADDR_STATE, 32'h0000_0100);
    wait_run(1'b1);
    reg_read_check(gpt_pkg::ADDR_STATE, 32'h0000_0000);
    restart_max();
    repeat (300) @(posedge pclk);
    check_flags(1'b0, 1'b0, 1'b1);
    check_word(max_count, 32'h0000_0010, "periodic top");
    reg_read_check(gpt_pkg::ADDR_STATE, 32'h0000_0004);
    // Fix field A while running, then compare all three
    reg_write(gpt_pkg::ADDR_IEN, 32'h0000_0004);
    reg_write(gpt_pkg::MATCH_HIGH_ADDR[0], 32'h0000_0000);
    reg_write(gpt_pkg::ADDR_IEN, 32'h0000_0007);
    repeat (300) @(posedge pclk);
    check_flags(1'b1, 1'b1, 1'b1);
    // Compare off, then clear: flags must stay low
    reg_write(gpt_pkg::ADDR_IEN, 32'h0000_0000);
    reg_write(gpt_pkg::ADDR_CLEAR, 32'h0000_0007);
    repeat (200) @(posedge pclk);
    check_flags(1'b0, 1'b0, 1'b0);
    reg_read_check(gpt_pkg::ADDR_STATE, 32'h0000_0000);
    // Disable returns the counter to its start value
    reg_write(gpt_pkg::ADDR_RUN, 32'h0000_0000);
    wait_run(1'b0);
    @(negedge pclk);
    check_word(count_value, 32'h0000_0000, "stopped count");
    reg_read_check(gpt_pkg::ADDR_STATE, 32'h0000_0000);
    // Free running passes field C; C writable while counting
    reg_write(gpt_pkg::ADDR_CONFIG, 32'h0000_0010);
    reg_write(gpt_pkg::ADDR_RUN, 32'h0000_0001);
    wait_run(1'b1);
    restart_max();
    repeat (200) @(posedge pclk);
    reg_write(gpt_pkg::MATCH_LOW_ADDR[2], 32'h0000_0020);
    reg_read_check(gpt_pkg::MATCH_LOW_ADDR[2], 32'h0000_0020);
    @(negedge pclk);
    check_bit(max_count > 32'h0000_0010, 1'b1, "free run past c");
    check_bit(roll_irq, 1'b0, "no roll");
    // Periodic down: all ones down to field C, then back to all ones
    reg_write(gpt_pkg::ADDR_RUN, 32'h0000_0000);
    wait_run(1'b0);
    reg_read_check(gpt_pkg::ADDR_STATE, 32'h0000_0000);
    reg_write(gpt_pkg::ADDR_CONFIG, 32'h0000_0004);
    reg_write(gpt_pkg::MATCH_LOW_ADDR[2], 32'h0000_fff0);
    reg_write(gpt_pkg::MATCH_HIGH_ADDR[2], 32'h0000_ffff);
    check_word(count_value, 32'hffff_ffff, "down start");
    reg_write(gpt_pkg::ADDR_IEN, 32'h0000_0004);
    reg_write(gpt_pkg::ADDR_RUN, 32'h0000_0001);
    wait_run(1'b1);
    repeat (200) @(posedge pclk);
    check_flags(1'b0, 1'b0, 1'b1);
    check_bit(count_value >= 32'hffff_fff0, 1'b1, "down range");
    conclude();
  end
endmodule
`default_nettype wire
